// ===== design/io_port_ir_pwm_wakeup.sv
// three 4-bit ports with ir carrier, pwm and stop-mode wake-up
`timescale 1ns/1ps
module io_port_ir_pwm_wakeup
  import io_port_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  input  wire logic [NUM_PINS-1:0] pin_in,
  output logic      [NUM_PINS-1:0] pin_out,
  output logic      [NUM_PINS-1:0] pin_oe,
  output logic      [NUM_PINS-1:0] pull_en,
  output logic                     stopped
);
  pwm_if pwm ();

  logic [NUM_PINS-1:0] sync1_q, sync2_q, prev_q;
  logic [4:0]          div_q;
  logic [3:0]          instr_q;
  logic [4:0]          ir_cnt_q;
  logic                carrier_q;
  logic                sys_tick, instr_tick, pin_edge;
  logic [NUM_PINS-1:0] dir_q, out_q, dir_act_q, out_act_q;
  logic [3:0]          mode_q, mode_act_q;
  logic [PWM_CH-1:0]   pwm_en_q, pwm_en_act_q;
  logic [DUTY_W-1:0]   duty_q [PWM_CH];
  logic [DUTY_W-1:0]   duty_act_q [PWM_CH];
  logic                wake_q;
  logic                wr_pend_q, rd_pend_q;
  logic [7:0]          addr_q;
  logic                take;
  logic [NUM_PINS-1:0] drive_d;
  logic                ir_src;

  // ------------------------------------------------------------
  // pin input synchronisers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q  <= '0;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  assign pin_edge = |(sync2_q ^ prev_q);

  // ------------------------------------------------------------
  // system clock enable and instruction cycle
  // ------------------------------------------------------------
  // divide to 2 MHz
  always_ff @(posedge ref_clk) begin
    if (rst || stopped) begin
      div_q <= '0;
    end else if (div_q == SYS_DIV_LAST) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 5'h01;
    end
  end

  assign sys_tick = !stopped && (div_q == SYS_DIV_LAST);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      instr_q <= '0;
    end else if (sys_tick) begin
      instr_q <= (instr_q == INSTR_LAST) ? 4'h0 : instr_q + 4'h1;
    end
  end

  assign instr_tick = sys_tick && (instr_q == INSTR_LAST);

  // ------------------------------------------------------------
  // stop mode and wake-up
  // ------------------------------------------------------------
  // stop entry and edge wake
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stopped <= 1'b0;
    end else if (stopped && pin_edge) begin
      stopped <= 1'b0;
    end else if (wr_pend_q && addr_q == OFS_POWER && hwdata[PWR_STOP]) begin
      stopped <= 1'b1;
    end
  end

  // wake flag: a new edge outweighs a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wake_q <= 1'b0;
    end else if (stopped && pin_edge) begin
      wake_q <= 1'b1;
    end else if (wr_pend_q && addr_q == OFS_POWER && hwdata[PWR_WAKE]) begin
      wake_q <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // ir carrier
  // ------------------------------------------------------------
  // toggle every 26 system ticks
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ir_cnt_q  <= '0;
      carrier_q <= 1'b0;
    end else if (sys_tick) begin
      if (ir_cnt_q == IR_HALF_LAST) begin
        ir_cnt_q  <= '0;
        carrier_q <= !carrier_q;
      end else begin
        ir_cnt_q <= ir_cnt_q + 5'h01;
      end
    end
  end

  // ------------------------------------------------------------
  // ahb-lite slave
  // ------------------------------------------------------------
  assign take = hsel && hready && (htrans == TRANS_NONSEQ);

  // reads take one wait state so a preceding write is visible
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q    <= '0;
      hreadyout <= 1'b1;
      hresp     <= RESP_OKAY;
    end else begin
      wr_pend_q <= take && hwrite;
      rd_pend_q <= take && !hwrite;
      hreadyout <= !(take && !hwrite);
      hresp     <= RESP_OKAY;
      if (take) begin
        addr_q <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hrdata <= '0;
    end else if (rd_pend_q) begin
      hrdata <= '0;
      unique case (addr_q)
        OFS_DIR:    hrdata[NUM_PINS-1:0] <= dir_q;
        OFS_OUT:    hrdata[NUM_PINS-1:0] <= out_q;
        OFS_IN:     hrdata[NUM_PINS-1:0] <= sync2_q;
        OFS_MODE:   hrdata[3:0] <= mode_q;
        OFS_PWM_EN: hrdata[PWM_CH-1:0] <= pwm_en_q;
        OFS_POWER:  hrdata[1:0] <= {wake_q, stopped};
        default: begin
          if (addr_q >= OFS_DUTY0 && addr_q <= OFS_DUTY3 &&
              addr_q[1:0] == 2'h0) begin
            hrdata[DUTY_W-1:0] <= duty_q[2'(addr_q[7:2] - OFS_DUTY0[7:2])];
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // software-visible registers
  // ------------------------------------------------------------
  // direction, data, mode, pwm enable and duty registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dir_q    <= DIR_RST;
      out_q    <= OUT_RST;
      mode_q   <= MODE_RST;
      pwm_en_q <= '0;
      for (int i = 0; i < PWM_CH; i++) begin
        duty_q[i] <= DUTY_RST;
      end
    end else if (wr_pend_q) begin
      if (addr_q == OFS_DIR)    dir_q    <= hwdata[NUM_PINS-1:0];
      if (addr_q == OFS_OUT)    out_q    <= hwdata[NUM_PINS-1:0];
      if (addr_q == OFS_MODE)   mode_q   <= hwdata[3:0];
      if (addr_q == OFS_PWM_EN) pwm_en_q <= hwdata[PWM_CH-1:0];
      for (int i = 0; i < PWM_CH; i++) begin
        if (addr_q == OFS_DUTY0 + 8'(4 * i)) begin
          duty_q[i] <= hwdata[DUTY_W-1:0];
        end
      end
    end
  end

  // settings take effect on instruction boundaries
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      dir_act_q    <= DIR_RST;
      out_act_q    <= OUT_RST;
      mode_act_q   <= MODE_RST;
      pwm_en_act_q <= '0;
      for (int i = 0; i < PWM_CH; i++) begin
        duty_act_q[i] <= DUTY_RST;
      end
    end else if (instr_tick) begin
      dir_act_q    <= dir_q;
      out_act_q    <= out_q;
      mode_act_q   <= mode_q;
      pwm_en_act_q <= pwm_en_q;
      duty_act_q   <= duty_q;
    end
  end

  // ------------------------------------------------------------
  // pwm bank
  // ------------------------------------------------------------
  assign pwm.tick = sys_tick;
  assign pwm.duty = duty_act_q;

  pwm_channels u_pwm (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pwm     (pwm)
  );

  // ------------------------------------------------------------
  // pin drive
  // ------------------------------------------------------------
  always_comb begin
    drive_d = out_act_q;
    for (int i = 0; i < PWM_CH; i++) begin
      if (pwm_en_act_q[i]) begin
        drive_d[PWM_BASE + i] = pwm.level[i];
      end
    end
    ir_src = drive_d[IR_PRI] && carrier_q;
    if (mode_act_q[MODE_IR_EN]) begin
      if (mode_act_q[MODE_IR_SEL]) begin
        drive_d[IR_ALT] = ir_src;
      end else begin
        drive_d[IR_PRI] = ir_src;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_out <= '0;
      pin_oe  <= '0;
      pull_en <= '1;
    end else begin
      pin_out <= drive_d & dir_act_q;
      pin_oe  <= dir_act_q;
      pull_en <= ~dir_act_q;
    end
  end
endmodule : io_port_ir_pwm_wakeup

// ===== pkg/io_port_pkg.sv
// constants, register map and field layout of the port block
package io_port_pkg;
  // ------------------------------------------------------------
  // clocking
  // ------------------------------------------------------------
  localparam int unsigned REF_CLK_HZ    = 50_000_000;
  localparam int unsigned SYS_CLK_HZ    = 2_000_000;
  localparam int unsigned SYS_DIV       = REF_CLK_HZ / SYS_CLK_HZ;
  localparam int unsigned INSTR_TIME_NS = 4000;
  localparam int unsigned INSTR_TICKS   =
    (INSTR_TIME_NS * (SYS_CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned IR_PERIOD     = 52;
  localparam int unsigned IR_HALF       = IR_PERIOD / 2;
  localparam logic [4:0]  SYS_DIV_LAST  = 5'(SYS_DIV - 1);
  localparam logic [3:0]  INSTR_LAST    = 4'(INSTR_TICKS - 1);
  localparam logic [4:0]  IR_HALF_LAST  = 5'(IR_HALF - 1);

  // ------------------------------------------------------------
  // geometry
  // ------------------------------------------------------------
  localparam int unsigned PORT_W    = 4;
  localparam int unsigned NUM_PINS  = 12;
  localparam int unsigned PWM_CH    = 4;
  localparam int unsigned DUTY_W    = 8;
  localparam int unsigned PWM_BASE  = 8;
  localparam int unsigned IR_PRI    = 11;
  localparam int unsigned IR_ALT    = 7;

  // ------------------------------------------------------------
  // register map (byte offsets)
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_DIR    = 8'h00;
  localparam logic [7:0] OFS_OUT    = 8'h04;
  localparam logic [7:0] OFS_IN     = 8'h08;
  localparam logic [7:0] OFS_MODE   = 8'h0c;
  localparam logic [7:0] OFS_PWM_EN = 8'h10;
  localparam logic [7:0] OFS_DUTY0  = 8'h14;
  localparam logic [7:0] OFS_DUTY3  = 8'h20;
  localparam logic [7:0] OFS_POWER  = 8'h24;

  localparam int unsigned MODE_IR_SEL = 1;
  localparam int unsigned MODE_IR_EN  = 3;
  localparam int unsigned PWR_STOP    = 0;
  localparam int unsigned PWR_WAKE    = 1;

  localparam logic [11:0] DIR_RST  = 12'h000;
  localparam logic [11:0] OUT_RST  = 12'h000;
  localparam logic [3:0]  MODE_RST = 4'h0;
  localparam logic [7:0]  DUTY_RST = 8'h00;

  localparam logic [1:0]  TRANS_NONSEQ = 2'h2;
  localparam logic        RESP_OKAY    = 1'b0;
endpackage : io_port_pkg

// ===== pkg/pwm_if.sv
// carrier between the port block and its pwm channel bank
`timescale 1ns/1ps
interface pwm_if;
  import io_port_pkg::*;
  logic                tick;
  logic [DUTY_W-1:0]   duty [PWM_CH];
  logic [PWM_CH-1:0]   level;
  modport ctrl (output tick, output duty, input level);
  modport chan (input tick, input duty, output level);
endinterface : pwm_if

// ===== design/pwm_channels.sv
// four pwm channels sharing one free-running 8-bit counter
`timescale 1ns/1ps
module pwm_channels
  import io_port_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst,
  pwm_if.chan       pwm
);
  logic [DUTY_W-1:0] cnt_q;

  // ------------------------------------------------------------
  // counter and compare
  // ------------------------------------------------------------
  // free-running counter
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (pwm.tick) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pwm.level <= '0;
    end else begin
      for (int i = 0; i < PWM_CH; i++) begin
        pwm.level[i] <= (cnt_q < pwm.duty[i]);
      end
    end
  end
endmodule : pwm_channels

// ===== testbench/io_port_checker.sv
// assertions on the port block's top-level ports
`timescale 1ns/1ps
module io_port_checker
  import io_port_pkg::*;
(
  input wire logic                ref_clk,
  input wire logic                rst,
  input wire logic                hsel,
  input wire logic [1:0]          htrans,
  input wire logic                hwrite,
  input wire logic                hready,
  input wire logic                hreadyout,
  input wire logic                hresp,
  input wire logic [NUM_PINS-1:0] pin_in,
  input wire logic [NUM_PINS-1:0] pin_out,
  input wire logic [NUM_PINS-1:0] pin_oe,
  input wire logic [NUM_PINS-1:0] pull_en,
  input wire logic                stopped
);
  // --------
  // checks
  // --------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence take;
    hsel && hready && htrans == TRANS_NONSEQ;
  endsequence
  sequence rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  // six cycles covers a tick already in flight at stop entry
  sequence held;
    stopped [*6];
  endsequence
  chk_read_wait: assert property (take and !hwrite |=> rd_wait)
    else $error("read wait state wrong");
  chk_write_nowait: assert property (take and hwrite |=> hreadyout)
    else $error("write wait state seen");
  chk_resp_okay: assert property (hresp == RESP_OKAY)
    else $error("response not okay");
  chk_pull_follow: assert property (pull_en == ~pin_oe)
    else $error("pull not opposite of drive");
  chk_input_quiet: assert property ((pin_out & ~pin_oe) == '0)
    else $error("input pin drives high");
  chk_wake_edge: assert property (stopped && $changed(pin_in)
    |-> ##[1:5] !stopped) else $error("pin edge did not wake");
  chk_stop_frozen: assert property (held |-> $stable(pin_out))
    else $error("pins move while stopped");
  chk_oe_settle: assert property ($changed(pin_oe)
    |=> $stable(pin_oe) [*8]) else $error("drive changes too often");
endmodule : io_port_checker

bind io_port_ir_pwm_wakeup io_port_checker chk_u (
  .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe(pin_oe), .pull_en(pull_en), .stopped(stopped));

// ===== testbench/pin_partner.sv
// keys and leds hanging on the twelve port pins
`timescale 1ns/1ps
module pin_partner (
  input  wire logic        ref_clk,
  input  wire logic [11:0] pin_out,
  input  wire logic [11:0] pin_oe,
  input  wire logic [11:0] pull_en,
  input  wire logic [11:0] key,
  output logic      [11:0] pin_in
);
  logic [11:0] last_q;
  // pulled-low inputs
  // an unpulled idle pin wanders so a stale level cannot pass
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & key)
                | (~pin_oe & ~pull_en & ~key & ~last_q);
  always_ff @(posedge ref_clk) last_q <= pin_in;
endmodule : pin_partner

// ===== testbench/io_port_ir_pwm_wakeup_test.sv
// self-checking bench for the port block
`timescale 1ns/1ps
module io_port_ir_pwm_wakeup_test;
  import io_port_pkg::*;
  logic        ref_clk = 0;
  logic        rst = 1;
  logic        hsel = 0;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = '0;
  logic        hwrite = 0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata, rd;
  logic        hreadyout, hresp, stopped;
  logic [11:0] pin_in, pin_out, pin_oe, pull_en;
  logic [11:0] key = '0;
  logic [7:0]  duty_tab [4] = '{8'h40, 8'h00, 8'hff, 8'h80};
  int          bad_count = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          n;
  always #10 ref_clk = ~ref_clk;
  io_port_ir_pwm_wakeup dut_u (.ref_clk(ref_clk), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pull_en(pull_en), .stopped(stopped));
  pin_partner key_u (.ref_clk(ref_clk), .pin_out(pin_out),
    .pin_oe(pin_oe), .pull_en(pull_en), .key(key), .pin_in(pin_in));
  // --------
  // helpers
  // --------
  task close_out;
    $display("checks %0d errors %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out
  // a stuck handshake is cut short here
  // non-blocking count so scenario timing reads a settled value
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      bad_count++;
      close_out;
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1;
    htrans <= TRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task settle;
    repeat (450) @(posedge ref_clk);
  endtask : settle
  task hi_count(input int idx, input int len);
    n = 0;
    repeat (len) begin
      @(posedge ref_clk);
      n += int'(pin_out[idx] === 1'b1);
    end
  endtask : hi_count
  task hi_run(input int idx);
    n = 0;
    while (pin_out[idx] !== 1'b0) @(posedge ref_clk);
    while (pin_out[idx] !== 1'b1) @(posedge ref_clk);
    while (pin_out[idx] === 1'b1) begin
      n++;
      @(posedge ref_clk);
    end
  endtask : hi_run
  // --------
  // scenarios
  // --------
  task t_regs;
    bus(0, OFS_DIR, 0);
    chk("dir reset", {20'h0, DIR_RST}, rd);
    bus(0, OFS_MODE, 0);
    chk("mode reset", {28'h0, MODE_RST}, rd);
    bus(1, OFS_DIR, 32'ha5c);
    bus(0, OFS_DIR, 0);
    chk("dir", 32'ha5c, rd);
    bus(0, 8'h3c, 0);
    chk("unmapped", 32'h0, rd);
  endtask : t_regs
  task t_pins;
    bus(1, OFS_OUT, 32'hfff);
    key <= 12'h5a3;
    settle;
    chk("oe", 32'ha5c, {20'h0, pin_oe});
    chk("out", 32'ha5c, {20'h0, pin_out});
    chk("pull", 32'h5a3, {20'h0, pull_en});
    bus(0, OFS_IN, 0);
    chk("in", 32'hfff, rd);
  endtask : t_pins
  task t_stop;
    bus(1, OFS_DIR, 0);
    key <= 12'h000;
    settle;
    bus(1, OFS_POWER, 32'h2);
    key <= 12'h001;
    repeat (10) @(posedge ref_clk);
    bus(0, OFS_POWER, 0);
    chk("run edge", 32'h0, rd);
    bus(1, OFS_POWER, 32'h1);
    repeat (300) @(posedge ref_clk);
    chk("stopped", 32'h1, {31'h0, stopped});
    key <= 12'h000;
    repeat (8) @(posedge ref_clk);
    chk("woke", 32'h0, {31'h0, stopped});
    bus(0, OFS_POWER, 0);
    chk("wake flag", 32'h2, rd);
  endtask : t_stop
  task t_pwm;
    bus(1, OFS_DIR, 32'hf00);
    bus(1, OFS_OUT, 0);
    for (int i = 0; i < PWM_CH; i++)
      bus(1, 8'(OFS_DUTY0 + 4 * i), {24'h0, duty_tab[i]});
    bus(1, OFS_PWM_EN, 32'hf);
    bus(0, OFS_DUTY3, 0);
    chk("duty3", {24'h0, duty_tab[3]}, rd);
    settle;
    for (int i = 0; i < PWM_CH; i++) begin
      hi_count(PWM_BASE + i, 256 * SYS_DIV);
      chk("pwm high", duty_tab[i] * SYS_DIV, n);
    end
  endtask : t_pwm
  // two direction changes land exactly one instruction apart
  task t_tick;
    int t0;
    bus(1, OFS_DIR, 32'h00f);
    while (pin_oe !== 12'h00f) @(posedge ref_clk);
    t0 = cyc;
    bus(1, OFS_DIR, 32'h0f0);
    while (pin_oe !== 12'h0f0) @(posedge ref_clk);
    chk("instr step", INSTR_TICKS * SYS_DIV, cyc - t0);
  endtask : t_tick
  task t_ir;
    bus(1, OFS_PWM_EN, 0);
    bus(1, OFS_DIR, 32'h880);
    bus(1, OFS_OUT, 32'h800);
    bus(1, OFS_MODE, 32'ha);
    settle;
    hi_run(IR_ALT);
    chk("alt run", IR_HALF * SYS_DIV, n);
    chk("pri plain", 32'h1, {31'h0, pin_out[IR_PRI]});
    bus(1, OFS_MODE, 32'h8);
    settle;
    hi_run(IR_PRI);
    chk("pri run", IR_HALF * SYS_DIV, n);
    chk("alt plain", 32'h0, {31'h0, pin_out[IR_ALT]});
    bus(1, OFS_MODE, 0);
    settle;
    hi_count(IR_PRI, IR_PERIOD * SYS_DIV);
    chk("ir off", IR_PERIOD * SYS_DIV, n);
  endtask : t_ir
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 0;
    @(posedge ref_clk);
    t_regs;
    t_pins;
    t_stop;
    t_pwm;
    t_tick;
    t_ir;
    close_out;
  end
endmodule : io_port_ir_pwm_wakeup_test
